// ### include/vco_cfg_pkg.sv
`default_nettype none

package vco_cfg_pkg;

  // Register indices; the byte address of each is four times its index.
  localparam logic [7:0] IDX_AMP_CAL_START = 8'h14;
  localparam logic [7:0] IDX_CAP_BANK_CODE = 8'h16;
  localparam logic [7:0] IDX_CORE_SELECT = 8'h17;
  localparam logic [7:0] IDX_RSVD_A = 8'h18;
  localparam logic [7:0] IDX_RSVD_B = 8'h19;
  localparam logic [7:0] IDX_RSVD_C = 8'h1c;
  localparam logic [7:0] IDX_RSVD_D = 8'h1d;
  localparam logic [7:0] IDX_DITHER_DOUBLER = 8'h1e;
  localparam logic [7:0] IDX_BUFFER_POWER = 8'h1f;
  localparam logic [7:0] IDX_RSVD_E = 8'h20;
  localparam logic [7:0] IDX_RSVD_F = 8'h21;
  localparam logic [7:0] IDX_DIVIDER_ENABLE = 8'h22;
  localparam logic [7:0] IDX_CAL_STATUS = 8'h23;
  localparam logic [7:0] IDX_CAL_CONTROL = 8'h24;

  // Number of stored 16-bit configuration words.
  localparam int NUM_WORDS = 12;
  localparam logic [7:0] WORD_IDX [NUM_WORDS] = '{
    IDX_AMP_CAL_START, IDX_CAP_BANK_CODE, IDX_CORE_SELECT, IDX_RSVD_A,
    IDX_RSVD_B, IDX_RSVD_C, IDX_RSVD_D, IDX_DITHER_DOUBLER,
    IDX_BUFFER_POWER, IDX_RSVD_E, IDX_RSVD_F, IDX_DIVIDER_ENABLE};

  // Values after reset; reserved words start at zero.
  localparam logic [15:0] RST_AMP_CAL_START = 16'h012c;
  localparam logic [15:0] RST_CAP_BANK_CODE = 16'h0000;
  localparam logic [15:0] RST_CORE_SELECT = 16'h0800;
  localparam logic [15:0] RST_RESERVED = 16'h0000;
  localparam logic [15:0] RST_DITHER_DOUBLER = 16'h0000;
  localparam logic [15:0] RST_BUFFER_POWER = 16'h0400;
  localparam logic [15:0] RST_DIVIDER_ENABLE = 16'h0020;
  localparam logic [15:0] WORD_RST [NUM_WORDS] = '{
    RST_AMP_CAL_START, RST_CAP_BANK_CODE, RST_CORE_SELECT, RST_RESERVED,
    RST_RESERVED, RST_RESERVED, RST_RESERVED, RST_DITHER_DOUBLER,
    RST_BUFFER_POWER, RST_RESERVED, RST_RESERVED, RST_DIVIDER_ENABLE};

  // Field positions.
  localparam int AMP_START_LSB = 0;
  localparam int AMP_START_W = 9;
  localparam int CAP_CODE_LSB = 0;
  localparam int CAP_CODE_W = 8;
  localparam int START_OPTION_BIT = 14;
  localparam int CORE_SEL_LSB = 11;
  localparam int CORE_SEL_W = 3;
  localparam int FORCED_CORE_BIT = 10;
  localparam int DITHER_BIT = 10;
  localparam int DOUBLER_BIT = 0;
  localparam int OUT_B_PD_BIT = 10;
  localparam int OUT_A_PD_BIT = 9;
  localparam int DIV_FEED_PD_BIT = 7;
  localparam int DIV_ENABLE_BIT = 5;
  localparam int CAL_START_BIT = 0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_FAIL_BIT = 2;
  localparam int ST_CAL_CORE_LSB = 4;
  localparam int ST_OP_CORE_LSB = 8;
  localparam int ST_MANUAL_BIT = 12;

  // Core from which an undirected frequency search begins, and the lowest core, below which it fails.
  localparam logic [2:0] TOP_CORE = 3'h7;
  localparam logic [2:0] BOTTOM_CORE = 3'h0;

  // Frequency search states.
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_SEARCH = 2'b01,
    CAL_DONE = 2'b10
  } cal_state_t;

  // Configuration fields as seen by the analog blocks.
  typedef struct packed {
    logic [8:0] ampCalStartValue;
    logic [7:0] capacitorBankCode;
    logic calStartCoreOption;
    logic [2:0] coreSelect;
    logic forcedCoreSelection;
    logic modulatorDither;
    logic oscDoublerEnable;
    logic outputBBufferPowerdown;
    logic outputABufferPowerdown;
    logic dividerFeedBufferPowerdown;
    logic channelDividerMasterEnable;
  } osc_cfg_t;

  // Oscillator operating point chosen by the block.
  typedef struct packed {
    logic manualMode;
    logic [2:0] core;
    logic [7:0] capCode;
  } osc_point_t;

endpackage

`default_nettype wire

// ### rtl/ahb_reg_port.sv
`timescale 1ns/1ns
`default_nettype none

// Zero-wait AHB-Lite front end: decodes the address phase and replays
// writes in the following data phase.
module ahb_reg_port (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // AHB-Lite slave side.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  // Register side.
  output logic rdReq,
  output logic [7:0] rdIdx,
  output logic wrEn,
  output logic [7:0] wrIdx
);

  logic addrOk;
  logic take;
  logic wrPendQ;
  logic [7:0] wrIdxQ;

  // A word-aligned address inside the small register window.
  assign addrOk = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
  // Address phase accepted: selected, NONSEQ or SEQ, and bus ready.
  assign take = hsel && htrans[1] && hready;
  assign rdReq = take && !hwrite && addrOk;
  assign rdIdx = haddr[9:2];
  assign wrEn = wrPendQ;
  assign wrIdx = wrIdxQ;

  // Remembers a write so it lands with hwdata in the data phase.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPendQ <= 1'b0;
      wrIdxQ <= 8'h00;
    end else if (hready) begin
      wrPendQ <= take && hwrite && addrOk;
      wrIdxQ <= haddr[9:2];
    end
  end

  // The slave never stalls and always answers OKAY.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ### rtl/freq_cal_stepper.sv
`timescale 1ns/1ns
`default_nettype none

// Walks the oscillator cores downward, one per cycle, until the
// comparator reports the target band or the lowest core is tried without a match.
module freq_cal_stepper (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Control.
  input wire logic startPulse,
  input wire logic startOption,
  input wire logic [2:0] startCoreSel,
  input wire logic targetReached,
  // State.
  output logic [2:0] calCore,
  output logic busy,
  output logic done,
  output logic failed
);

  vco_cfg_pkg::cal_state_t stateQ;

  // Search sequencer.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stateQ <= vco_cfg_pkg::CAL_IDLE;
      calCore <= vco_cfg_pkg::TOP_CORE;
      failed <= 1'b0;
    end else if (startPulse) begin
      // Start at the top core unless the start-core option names one.
      stateQ <= vco_cfg_pkg::CAL_SEARCH;
      calCore <= startOption ? startCoreSel : vco_cfg_pkg::TOP_CORE;
      failed <= 1'b0;
    end else begin
      unique case (stateQ)
        vco_cfg_pkg::CAL_IDLE: begin
          stateQ <= vco_cfg_pkg::CAL_IDLE;
        end
        vco_cfg_pkg::CAL_SEARCH: begin
          if (targetReached) begin
            stateQ <= vco_cfg_pkg::CAL_DONE;
          end else if (calCore == vco_cfg_pkg::BOTTOM_CORE) begin
            // Nothing left below; report a failed search.
            stateQ <= vco_cfg_pkg::CAL_DONE;
            failed <= 1'b1;
          end else begin
            calCore <= calCore - 3'h1;
          end
        end
        vco_cfg_pkg::CAL_DONE: begin
          stateQ <= vco_cfg_pkg::CAL_DONE;
        end
        default: begin
          stateQ <= vco_cfg_pkg::CAL_IDLE;
        end
      endcase
    end
  end

  assign busy = (stateQ == vco_cfg_pkg::CAL_SEARCH);
  assign done = (stateQ == vco_cfg_pkg::CAL_DONE);

endmodule

`default_nettype wire

// ### rtl/vco_cal_and_output_path_config.sv
`timescale 1ns/1ns
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
module vco_cal_and_output_path_config (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Control bits held in neighbouring registers.
  input wire logic capacitorOverride,
  input wire logic frequencyCalEnable,
  // Comparator pin from the analog search, asynchronous.
  input wire logic targetReachedPin,
  // Configuration and operating point toward the analog blocks.
  output vco_cfg_pkg::osc_cfg_t oscCfg,
  output vco_cfg_pkg::osc_point_t oscPoint
);

  //////////////////////////////////////////////////////////////////////////
  // Declarations.

  // Stored configuration words, one per register number.
  logic [15:0] wordQ [vco_cfg_pkg::NUM_WORDS];
  // One-hot hit of the write and read index on each stored word.
  logic [vco_cfg_pkg::NUM_WORDS-1:0] wrHit;
  logic [vco_cfg_pkg::NUM_WORDS-1:0] rdHit;
  // Decoded bus strobes.
  logic rdReq;
  logic [7:0] rdIdx;
  logic wrEn;
  logic [7:0] wrIdx;
  // Read data of a stored word and of the status word. The read register
  // is loaded only in a read address phase, so it stands through the data
  // phase even while the next address phase is on the bus.
  logic [15:0] wordRead;
  logic [15:0] statusWord;
  logic [31:0] hrdataD;
  logic [31:0] hrdataQ;
  // Synchroniser stages for the comparator pin. Only the second stage is
  // read by logic; the first may be metastable for part of a cycle.
  logic targetMetaQ;
  logic targetSyncQ;
  // Frequency search start and state. The start pulse is registered to
  // keep the bus decode out of the search sequencer's timing path.
  logic calStartQ;
  logic calStartD;
  logic [2:0] calCore;
  logic calBusy;
  logic calDone;
  logic calFailed;
  // Operating point registers. Core and code load on the same edge, so
  // the analog side never sees them out of step.
  logic manualQ;
  logic [2:0] opCoreQ;
  logic [7:0] opCapQ;
  logic manualD;

  //////////////////////////////////////////////////////////////////////////
  // Bus front end.

  // Decodes address phases and delays writes to their data phase.
  // The bus never stalls: every transfer takes one address cycle and one
  // data cycle, and misaligned or far addresses are answered OKAY but
  // neither stored nor read.
  ahb_reg_port busPort (
    .clk(clk),
    .reset_n(reset_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .rdReq(rdReq),
    .rdIdx(rdIdx),
    .wrEn(wrEn),
    .wrIdx(wrIdx)
  );

  //////////////////////////////////////////////////////////////////////////
  // Register storage.

  // One flop word per register number, each written whole from hwdata.
  // Reserved words are kept like the named ones, so a host that writes
  // the default map reads the same values back. Bits 31:16 of hwdata
  // are dropped, since every word is 16 bits wide.
  generate
    for (genvar i = 0; i < vco_cfg_pkg::NUM_WORDS; i++) begin : gWord
      // Each word matches its own index for a write and for a read.
      assign wrHit[i] = wrEn && (wrIdx == vco_cfg_pkg::WORD_IDX[i]);
      assign rdHit[i] = (rdIdx == vco_cfg_pkg::WORD_IDX[i]);

      // Reset takes the documented default, writes replace the word.
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          wordQ[i] <= vco_cfg_pkg::WORD_RST[i];
        end else if (wrHit[i]) begin
          wordQ[i] <= hwdata[15:0];
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Read path.

  // Selects the addressed stored word; a write in its data phase to the
  // same word is forwarded so back-to-back write then read sees new data.
  // Without it a read right after a write would return the old word.
  always_comb begin
    wordRead = 16'h0000;
    for (int i = 0; i < vco_cfg_pkg::NUM_WORDS; i++) begin
      if (rdHit[i]) begin
        wordRead = wrHit[i] ? hwdata[15:0] : wordQ[i];
      end
    end
  end

  // Status word reports the search and the operating core and mode. It is
  // read-only: a write to its index matches no stored word and is lost.
  always_comb begin
    statusWord = 16'h0000;
    statusWord[vco_cfg_pkg::ST_BUSY_BIT] = calBusy;
    statusWord[vco_cfg_pkg::ST_DONE_BIT] = calDone;
    statusWord[vco_cfg_pkg::ST_FAIL_BIT] = calFailed;
    statusWord[vco_cfg_pkg::ST_CAL_CORE_LSB +: 3] = calCore;
    statusWord[vco_cfg_pkg::ST_OP_CORE_LSB +: 3] = opCoreQ;
    statusWord[vco_cfg_pkg::ST_MANUAL_BIT] = manualQ;
  end

  // Read data for the next data phase; unmapped words read zero.
  // Between reads the register keeps its last value.
  always_comb begin
    hrdataD = hrdataQ;
    if (rdReq) begin
      if (rdIdx == vco_cfg_pkg::IDX_CAL_STATUS) begin
        hrdataD = {16'h0000, statusWord};
      end else begin
        // Control word is write-only and reads zero.
        hrdataD = {16'h0000, wordRead};
      end
    end
  end

  // Read data register, loaded in the address phase of a read.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdataQ <= 32'h00000000;
    end else begin
      hrdataQ <= hrdataD;
    end
  end

  // Read data leave the block straight from the read register.
  assign hrdata = hrdataQ;

  //////////////////////////////////////////////////////////////////////////
  // Configuration outputs.

  // Fields of the stored words drive the analog controls directly; no
  // extra stage is added, so a field changes in the cycle after its write.
  // Calibration helpers: amplitude start, capacitor code and core fields.
  assign oscCfg.ampCalStartValue =
    wordQ[0][vco_cfg_pkg::AMP_START_LSB +: vco_cfg_pkg::AMP_START_W];
  assign oscCfg.capacitorBankCode =
    wordQ[1][vco_cfg_pkg::CAP_CODE_LSB +: vco_cfg_pkg::CAP_CODE_W];
  assign oscCfg.calStartCoreOption = wordQ[2][vco_cfg_pkg::START_OPTION_BIT];
  assign oscCfg.coreSelect =
    wordQ[2][vco_cfg_pkg::CORE_SEL_LSB +: vco_cfg_pkg::CORE_SEL_W];
  assign oscCfg.forcedCoreSelection = wordQ[2][vco_cfg_pkg::FORCED_CORE_BIT];

  // Modulator dither and oscillator doubler share one word.
  assign oscCfg.modulatorDither = wordQ[7][vco_cfg_pkg::DITHER_BIT];
  assign oscCfg.oscDoublerEnable = wordQ[7][vco_cfg_pkg::DOUBLER_BIT];

  // Buffer power-downs: a set bit turns its buffer off.
  assign oscCfg.outputBBufferPowerdown = wordQ[8][vco_cfg_pkg::OUT_B_PD_BIT];
  assign oscCfg.outputABufferPowerdown = wordQ[8][vco_cfg_pkg::OUT_A_PD_BIT];
  assign oscCfg.dividerFeedBufferPowerdown =
    wordQ[8][vco_cfg_pkg::DIV_FEED_PD_BIT];

  // Divider master enable: a clear bit powers the whole divider down.
  assign oscCfg.channelDividerMasterEnable =
    wordQ[11][vco_cfg_pkg::DIV_ENABLE_BIT];

  //////////////////////////////////////////////////////////////////////////
  // Frequency search.

  // Two-flop synchroniser for the comparator pin. The pin comes from the
  // analog comparator and is not timed to clk, so the search sees it two
  // cycles after it moves.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      targetMetaQ <= 1'b0;
      targetSyncQ <= 1'b0;
    end else begin
      targetMetaQ <= targetReachedPin;
      targetSyncQ <= targetMetaQ;
    end
  end

  // A start write runs the search only when it is enabled and the
  // capacitor override is not bypassing it.
  // Any other value written to the control word is ignored.
  assign calStartD = wrEn && (wrIdx == vco_cfg_pkg::IDX_CAL_CONTROL) &&
    hwdata[vco_cfg_pkg::CAL_START_BIT] && frequencyCalEnable &&
    !capacitorOverride;

  // Start pulse register, one cycle long.
  // It follows the data phase of the control write by one cycle.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      calStartQ <= 1'b0;
    end else begin
      calStartQ <= calStartD;
    end
  end

  // Core search from the top core or from the selected start core.
  // The start option and core select are taken at the start pulse only;
  // writing them during a running search does not steer it.
  freq_cal_stepper calStepper (
    .clk(clk),
    .reset_n(reset_n),
    .startPulse(calStartQ),
    .startOption(oscCfg.calStartCoreOption),
    .startCoreSel(oscCfg.coreSelect),
    .targetReached(targetSyncQ),
    .calCore(calCore),
    .busy(calBusy),
    .done(calDone),
    .failed(calFailed)
  );

  //////////////////////////////////////////////////////////////////////////
  // Operating point.

  // Manual mode needs both the capacitor override and forced selection.
  assign manualD = capacitorOverride && oscCfg.forcedCoreSelection;

  // Manual mode takes the selected core and the programmed code;
  // otherwise the core follows the search and the code is held unless the capacitor override is set.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      manualQ <= 1'b0;
      opCoreQ <= vco_cfg_pkg::TOP_CORE;
      opCapQ <= 8'h00;
    end else begin
      manualQ <= manualD;
      if (manualD) begin
        // Manual mode: core and code come from the registers.
        opCoreQ <= oscCfg.coreSelect;
        opCapQ <= oscCfg.capacitorBankCode;
      end else if (capacitorOverride) begin
        // Override without forcing keeps the search core, fixes the code.
        opCoreQ <= calCore;
        opCapQ <= oscCfg.capacitorBankCode;
      end else begin
        // Automatic mode: the core follows the search, the code is held.
        opCoreQ <= calCore;
      end
    end
  end

  // The operating point leaves the block straight from its registers.
  assign oscPoint.manualMode = manualQ;
  assign oscPoint.core = opCoreQ;
  assign oscPoint.capCode = opCapQ;

  // Transfer size is not checked; only whole words are issued. A narrower
  // write would still replace the whole addressed word.
  logic unusedSize;
  assign unusedSize = ^hsize;

endmodule

`default_nettype wire

// ### verif/vco_cfg_checker_sva.sv
`timescale 1ns/1ns
`default_nettype none

// Watches the register bus and the outputs of the configuration bank.
module vco_cfg_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // AHB-Lite slave side.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Analog side.
  input wire logic capacitorOverride,
  input wire vco_cfg_pkg::osc_cfg_t oscCfg,
  input wire vco_cfg_pkg::osc_point_t oscPoint
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic wrPend_q; // A write data phase is under way.
  logic [7:0] wrIdx_q; // Register index of that write.

  //////////////////////////////////////////////////////////////////////////
  // Follows each accepted, aligned write into its data phase.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPend_q <= 1'b0;
      wrIdx_q <= 8'h00;
    end else begin
      wrPend_q <= hsel && htrans[1] && hready && hwrite &&
        haddr[31:10] == 22'h0 && haddr[1:0] == 2'h0;
      wrIdx_q <= haddr[9:2];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  AST_BUS: assert property (hreadyout && !hresp)
    else $error("Bus answer not ready or not OKAY.");
  AST_RESET: assert property ($rose(reset_n) |-> oscCfg ==
    {9'd300, 8'h00, 1'b0, 3'h1, 3'h0, 1'b1, 2'h0, 1'b1})
    else $error("Fields not at reset values.");
  AST_AMP: assert property (wrPend_q && wrIdx_q == vco_cfg_pkg::IDX_AMP_CAL_START |=>
    oscCfg.ampCalStartValue == $past(hwdata[8:0])) else $error("Amplitude start not written.");
  AST_CAP: assert property (wrPend_q && wrIdx_q == vco_cfg_pkg::IDX_CAP_BANK_CODE |=>
    oscCfg.capacitorBankCode == $past(hwdata[7:0])) else $error("Capacitor code not written.");
  AST_CORE: assert property (wrPend_q && wrIdx_q == vco_cfg_pkg::IDX_CORE_SELECT |=>
    {oscCfg.calStartCoreOption, oscCfg.coreSelect, oscCfg.forcedCoreSelection} ==
    $past(hwdata[14:10])) else $error("Core fields not written.");
  AST_DITHER: assert property (wrPend_q && wrIdx_q == vco_cfg_pkg::IDX_DITHER_DOUBLER |=>
    {oscCfg.modulatorDither, oscCfg.oscDoublerEnable} == {$past(hwdata[10]), $past(hwdata[0])})
    else $error("Dither word not written.");
  AST_BUFFER: assert property (wrPend_q && wrIdx_q == vco_cfg_pkg::IDX_BUFFER_POWER |=>
    {oscCfg.outputBBufferPowerdown, oscCfg.outputABufferPowerdown,
    oscCfg.dividerFeedBufferPowerdown} == {$past(hwdata[10:9]), $past(hwdata[7])})
    else $error("Buffer power word not written.");
  AST_DIVEN: assert property (wrPend_q && wrIdx_q == vco_cfg_pkg::IDX_DIVIDER_ENABLE |=>
    oscCfg.channelDividerMasterEnable == $past(hwdata[5])) else $error("Divider enable not written.");
  AST_HOLD: assert property (!wrPend_q |=> $stable(oscCfg))
    else $error("Fields changed without a write.");
  AST_MANUAL: assert property (capacitorOverride && oscCfg.forcedCoreSelection |=>
    oscPoint == {1'b1, $past(oscCfg.coreSelect), $past(oscCfg.capacitorBankCode)})
    else $error("Manual point not taken.");
  AST_OVR_ONLY: assert property (capacitorOverride && !oscCfg.forcedCoreSelection |=>
    !oscPoint.manualMode && oscPoint.capCode == $past(oscCfg.capacitorBankCode))
    else $error("Override alone misbehaves.");
  AST_AUTO: assert property (!capacitorOverride |=> !oscPoint.manualMode)
    else $error("Manual mode without override.");
endmodule

bind vco_cal_and_output_path_config vco_cfg_checker i_vco_cfg_checker (
  .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout),
  .hresp(hresp), .capacitorOverride(capacitorOverride), .oscCfg(oscCfg),
  .oscPoint(oscPoint));

`default_nettype wire

// ### verif/vco_cal_and_output_path_config_test.sv
`timescale 1ns/1ns
`default_nettype none

// Compares a value with its expectation and counts the outcome.
`define CHECK(act, exp) begin cmpCount++; if ((act) !== (exp)) begin numErrors++; \
  $display("ERROR %0t: got %h, expected %h", $time, (act), (exp)); end end

module vco_cal_and_output_path_config_test;
  logic clk, reset_n, hsel, hwrite, hreadyout, hresp; // Clock, reset and bus controls.
  logic [31:0] haddr, hwdata, hrdata, rd; // Bus address and data.
  logic [1:0] htrans; // Transfer kind.
  logic [2:0] hsize; // Transfer size, always a word.
  logic capacitorOverride, frequencyCalEnable, targetReachedPin; // Neighbour controls.
  vco_cfg_pkg::osc_cfg_t oscCfg; // Fields toward the analog blocks.
  vco_cfg_pkg::osc_point_t oscPoint; // Chosen operating point.
  int numErrors = 0; // Mismatches seen.
  int cmpCount = 0; // Comparisons made.

  // The single slave's ready is the bus ready.
  vco_cal_and_output_path_config i_vco_cal_and_output_path_config (
    .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .capacitorOverride(capacitorOverride), .frequencyCalEnable(frequencyCalEnable),
    .targetReachedPin(targetReachedPin), .oscCfg(oscCfg), .oscPoint(oscPoint));

  //////////////////////////////////////////////////////////////////////////
  // Makes the 100 ns clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Prints the counts and the verdict, then stops.
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmpCount, numErrors);
    if (numErrors == 0 && cmpCount > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One single AHB-Lite transfer; the address phase is held until ready.
  task automatic busXfer(input logic wr, input logic [7:0] idx, input logic [31:0] data,
      output logic [31:0] rdData);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? data : 32'h0;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdData = hrdata;
    #1;
  endtask

  // Writes one word, discarding the returned data.
  task automatic writeReg(input logic [7:0] idx, input logic [31:0] data);
    busXfer(1'b1, idx, data, rd);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Resets the block and reads every stored word back.
  task automatic testReset();
    logic [15:0] expWord [12];
    expWord = '{16'h012c, 16'h0, 16'h0800, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
      16'h0400, 16'h0, 16'h0, 16'h0020};
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      busXfer(1'b0, vco_cfg_pkg::WORD_IDX[i], 32'h0, rd);
      `CHECK(rd, {16'h0, expWord[i]})
    end
    `CHECK(oscPoint, {1'b0, 3'h7, 8'h00})
    $display("Test reset finished.");
  endtask

  // Writes boundary values, three with junk in the upper half, and reads them back.
  task automatic testFields();
    logic [7:0] idxs [6];
    logic [31:0] vals [6];
    idxs = '{vco_cfg_pkg::IDX_AMP_CAL_START, vco_cfg_pkg::IDX_CAP_BANK_CODE,
      vco_cfg_pkg::IDX_CORE_SELECT, vco_cfg_pkg::IDX_DITHER_DOUBLER,
      vco_cfg_pkg::IDX_BUFFER_POWER, vco_cfg_pkg::IDX_DIVIDER_ENABLE};
    vals = '{32'hdead_01ff, 32'hffff_00b7, 32'h0000_6c00, 32'h1234_0401, 32'h0000_0280, 32'h0};
    for (int i = 0; i < 6; i++) begin
      writeReg(idxs[i], vals[i]);
      busXfer(1'b0, idxs[i], 32'h0, rd);
      `CHECK(rd, {16'h0, vals[i][15:0]})
    end
    `CHECK(oscCfg, {9'h1ff, 8'hb7, 1'b1, 3'h5, 3'h7, 3'h3, 1'b0})
    writeReg(vco_cfg_pkg::IDX_DITHER_DOUBLER, 32'h0);
    writeReg(vco_cfg_pkg::IDX_BUFFER_POWER, 32'h0400);
    writeReg(vco_cfg_pkg::IDX_DIVIDER_ENABLE, 32'h0020);
    `CHECK(oscCfg[4:0], 5'b01001)
    writeReg(vco_cfg_pkg::IDX_RSVD_C, {16'h0, vco_cfg_pkg::RST_RESERVED});
    `CHECK(oscCfg[4:0], 5'b01001)
    writeReg(8'h15, 32'h0000_5a5a);
    busXfer(1'b0, 8'h15, 32'h0, rd);
    `CHECK(rd, 32'h0)
    $display("Test fields finished.");
  endtask

  // Drives the capacitor override with and without forced core selection.
  task automatic testManual();
    writeReg(vco_cfg_pkg::IDX_CORE_SELECT, 32'h6c00);
    capacitorOverride <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHECK(oscPoint, {1'b1, 3'h5, 8'hb7})
    writeReg(vco_cfg_pkg::IDX_CORE_SELECT, 32'h2800);
    repeat (2) @(posedge clk);
    #1;
    `CHECK({oscPoint.manualMode, oscPoint.capCode}, {1'b0, 8'hb7})
    capacitorOverride <= 1'b0;
    $display("Test manual finished.");
  endtask

  // Starts a search, waits for it to settle and judges the status word.
  task automatic calRun(input logic [31:0] coreWord, input logic [2:0] expCore,
      input logic [2:0] expBits);
    writeReg(vco_cfg_pkg::IDX_CORE_SELECT, coreWord);
    writeReg(vco_cfg_pkg::IDX_CAL_CONTROL, 32'h1);
    repeat (2) @(posedge clk);
    rd = 32'h1;
    for (int n = 0; n < 30 && rd[0] !== 1'b0; n++) begin
      busXfer(1'b0, vco_cfg_pkg::IDX_CAL_STATUS, 32'h0, rd);
    end
    `CHECK({rd[10:8], rd[6:4], rd[2:0]}, {expCore, expCore, expBits})
  endtask

  // Searches from the top core, from a chosen core, to failure, and refused.
  task automatic testSearch();
    frequencyCalEnable <= 1'b1;
    targetReachedPin <= 1'b1;
    calRun(32'h0000, 3'h7, 3'b010);
    calRun(32'h5800, 3'h3, 3'b010);
    `CHECK(oscPoint.core, 3'h3)
    targetReachedPin <= 1'b0;
    calRun(32'h0000, 3'h0, 3'b110);
    frequencyCalEnable <= 1'b0;
    calRun(32'h5800, 3'h0, 3'b110);
    $display("Test search finished.");
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Main sequence, ending with a second reset in mid-run.
  initial begin
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    capacitorOverride = 1'b0;
    frequencyCalEnable = 1'b0;
    targetReachedPin = 1'b0;
    testReset();
    testFields();
    testManual();
    testSearch();
    testReset();
    test_done();
  end

  // Cuts a hang short well beyond the expected run time.
  initial begin
    #1000000;
    numErrors++;
    test_done();
  end
endmodule

`default_nettype wire
